// >>> bench/mdu_pipe_model.sv
// pipeline-side model: issues operations and reads result registers
// assumes the unit's clock; clears outputs by blocking at time zero, then drives only by nonblocking at rising edges
`default_nettype none
module mdu_pipe_model
	import mdu_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        busy,
	input  wire logic        rd_valid,
	input  wire logic [63:0] rd_data,
	output var  mdu_issue_t  iss,
	output var  logic        rd_req,
	output var  logic        rd_sel
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		iss = '0;
		rd_req = 1'b0;
		rd_sel = 1'b0;
	end

	task automatic issue(input mdu_op_t op, input logic [63:0] a, b);
		@(posedge sys_clk);
		iss <= '{1'b1, op, a, b};
		@(posedge sys_clk);
		// operands flipped once dropped, so stale values never match
		iss <= '{1'b0, op, ~a, ~b};
	endtask : issue

	task automatic wait_idle(output int n);
		n = 0;
		for (int k = 0; k < 60; k++) begin
			@(posedge sys_clk);
			if (busy)
				n++;
			else if (n > 0)
				break;
		end
	endtask : wait_idle

	task automatic read_res(input logic sel, output logic [63:0] d,
		output int n);
		n = 0;
		@(posedge sys_clk);
		rd_req <= 1'b1;
		rd_sel <= sel;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rd_valid !== 1'b1 && n < 60);
		d = rd_data;
		rd_req <= 1'b0;
		rd_sel <= ~sel;
	endtask : read_res
endmodule : mdu_pipe_model
`default_nettype wire

// >>> bench/multiply_divide_unit_tb.sv
// self-checking bench for the multiply/divide unit
// assumes the pipeline model drives all unit inputs but clock and reset
`default_nettype none
module multiply_divide_unit_tb
	import mdu_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk;
	logic        sys_rst;
	logic        rd_req;
	logic        rd_sel;
	logic        busy;
	logic        rd_valid;
	logic        gpr_wr_valid;
	logic [63:0] rd_data;
	logic [63:0] gpr_wr_data;
	mdu_issue_t  iss;
	int          num_errors = 0;
	int          check_count = 0;
	logic [63:0] up;
	logic [63:0] bot;

	mdu_unit mdu_unit_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .iss(iss),
		.rd_req(rd_req), .rd_sel(rd_sel), .busy(busy),
		.rd_valid(rd_valid), .rd_data(rd_data),
		.gpr_wr_valid(gpr_wr_valid), .gpr_wr_data(gpr_wr_data));
	mdu_pipe_model mdu_pipe_model_i (.sys_clk(sys_clk), .busy(busy),
		.rd_valid(rd_valid), .rd_data(rd_data), .iss(iss),
		.rd_req(rd_req), .rd_sel(rd_sel));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input logic [63:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	// busy span fixed per kind; divides take 16 or 32 of the 35 cycles
	task automatic run_op(input mdu_op_t op, input logic [63:0] a, b,
		input int cyc, input logic [63:0] eu, eb);
		int n;
		mdu_pipe_model_i.issue(op, a, b);
		mdu_pipe_model_i.wait_idle(n);
		check(64'(n), 64'(cyc));
		mdu_pipe_model_i.read_res(1'b1, up, n);
		check(up, eu);
		check(64'(n), 64'h2);
		mdu_pipe_model_i.read_res(1'b0, bot, n);
		check(bot, eb);
		check(64'(n), 64'h2);
	endtask : run_op

	// request is sampled one edge after it is set, answer one edge later
	task automatic t_reset();
		int n;
		mdu_pipe_model_i.read_res(1'b1, up, n);
		check(up, 64'h0);
		check(64'(n), 64'h2);
		mdu_pipe_model_i.read_res(1'b0, bot, n);
		check(bot, 64'h0);
		check(64'(n), 64'h2);
		check(64'(busy), 64'h0);
	endtask : t_reset

	// reset mid-run clears the result pair and the bypass word
	task automatic t_mid_reset();
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		check(gpr_wr_data, 64'h0);
		t_reset();
	endtask : t_mid_reset

	task automatic t_word();
		run_op(MDU_OP_MULT, 64'hFFFFFFFD, 64'h7, 4,
			64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFEB);
		run_op(MDU_OP_MULTU, 64'hFFFFFFFD, 64'h7, 4,
			64'h6, 64'hFFFF_FFFF_FFFF_FFEB);
		run_op(MDU_OP_DIVU, 64'h64, 64'h7, 16, 64'h2, 64'hE);
		run_op(MDU_OP_DIVU, 64'h7, 64'h2, 16, 64'h1, 64'h3);
		// divide by zero runs to completion without a trap
		run_op(MDU_OP_DIVU, 64'h9, 64'h0, 16, 64'h9,
			64'hFFFF_FFFF_FFFF_FFFF);
		run_op(MDU_OP_DIV, 64'hFFFFFF9C, 64'h7, 16,
			64'hFFFF_FFFF_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFF2);
	endtask : t_word

	task automatic t_dbl();
		run_op(MDU_OP_DMULTU, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2, 4,
			64'h1, 64'hFFFF_FFFF_FFFF_FFFE);
		run_op(MDU_OP_DMULT, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2, 4,
			64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFE);
		run_op(MDU_OP_DDIV, 64'hFFFF_FFFF_FFFF_FF9C, 64'h7, 32,
			64'hFFFF_FFFF_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFF2);
		run_op(MDU_OP_DDIVU, 64'hFFFF_FFFF_FFFF_FFFF, 64'h10, 32,
			64'hF, 64'h0FFF_FFFF_FFFF_FFFF);
	endtask : t_dbl

	// accumulate carries from bottom into upper
	task automatic t_mad();
		run_op(MDU_OP_MULTU, 64'h3, 64'h5, 4, 64'h0, 64'hF);
		run_op(MDU_OP_MADU, 64'hFFFFFFFF, 64'h2, 4, 64'h2, 64'hD);
		run_op(MDU_OP_MAD, 64'hFFFFFFFF, 64'h1, 4, 64'h2, 64'hC);
		// zero product must leave the accumulator as it was
		run_op(MDU_OP_MADU, 64'h5, 64'h0, 4, 64'h2, 64'hC);
	endtask : t_mad

	// product goes straight to the destination register
	task automatic t_mul3();
		int k;
		mdu_pipe_model_i.issue(MDU_OP_MUL3, 64'h6, 64'hFFFFFFF9);
		for (k = 0; k < 10 && gpr_wr_valid !== 1'b1; k++)
			@(posedge sys_clk);
		check(64'(k), 64'h5);
		check(64'(gpr_wr_valid), 64'h1);
		check(gpr_wr_data, 64'hFFFF_FFFF_FFFF_FFD6);
	endtask : t_mul3

	// read right behind a divide must stall, not answer stale data
	task automatic t_stall();
		int n;
		mdu_pipe_model_i.issue(MDU_OP_DIVU, 64'h64, 64'h7);
		mdu_pipe_model_i.read_res(1'b0, bot, n);
		check(64'(n > 16), 64'h1);
		check(bot, 64'hE);
	endtask : t_stall

	initial begin
		sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_word();
		t_dbl();
		t_mad();
		t_mul3();
		t_mid_reset();
		t_stall();
		stop_test();
	end

	// whole run is well under 2000 cycles
	initial begin
		#(20000 * 8);
		num_errors++;
		stop_test();
	end
endmodule : multiply_divide_unit_tb
`default_nettype wire

// >>> core/mdu_unit.sv
// multiply/divide unit with interlocked upper/lower result registers
// assumes the pipeline issues only while busy is low and holds a read
// request until rd_valid answers it
`default_nettype none
`include "mdu_regs.svh"

module mdu_unit
	import mdu_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire mdu_issue_t  iss,
	input  wire logic        rd_req,
	input  wire logic        rd_sel,
	output logic             busy,
	output logic             rd_valid,
	output logic [63:0]      rd_data,
	output logic             gpr_wr_valid,
	output logic [63:0]      gpr_wr_data
);

	mdu_state_t st_q;
	mdu_state_t st_d;

	function automatic logic [63:0] sx32(input logic [31:0] v);
		sx32 = {{32{v[31]}}, v};
	endfunction : sx32

	logic         take;
	logic         uns;
	logic         dw;
	logic [63:0]  a_ext;
	logic [63:0]  b_ext;
	logic [63:0]  a_abs;
	logic [63:0]  b_abs;
	logic         sa;
	logic         sb;
	logic [127:0] p;
	logic [64:0]  r;
	logic [63:0]  q;
	logic [63:0]  qf;
	logic [63:0]  rf;
	logic [63:0]  acc;

	assign take = iss.valid && (st_q.fsm == MDU_ST_IDLE);

	always_comb begin
		st_d = st_q;
		st_d.rd_valid = 1'b0;
		st_d.gpr_valid = 1'b0;
		uns = iss.op[0] && (iss.op != MDU_OP_MUL3);
		dw = (iss.op >= MDU_OP_DMULT) && (iss.op <= MDU_OP_DDIVU);
		// doubleword keeps all 64 operand bits
		a_ext = dw ? iss.source_a
			: (uns ? {32'h0, iss.source_a[31:0]} : sx32(iss.source_a[31:0]));
		b_ext = dw ? iss.source_b
			: (uns ? {32'h0, iss.source_b[31:0]} : sx32(iss.source_b[31:0]));
		sa = a_ext[63] && !uns;
		sb = b_ext[63] && !uns;
		a_abs = sa ? (64'h0 - a_ext) : a_ext;
		b_abs = sb ? (64'h0 - b_ext) : b_ext;
		p = a_abs * b_abs;
		if (sa ^ sb) begin
			p = 128'h0 - p;
		end
		r = st_q.rem;
		q = st_q.quo;
		qf = 64'h0;
		rf = 64'h0;
		acc = 64'h0;
		unique case (st_q.fsm)
			MDU_ST_IDLE: begin
				// answer a read only once nothing is in flight
				if (rd_req && !iss.valid && !st_q.rd_valid) begin
					st_d.rd_valid = 1'b1;
					st_d.rd_data = rd_sel ? st_q.upper_result
						: st_q.bottom_result;
				end
				if (iss.valid) begin
					st_d.op = iss.op;
					st_d.busy = 1'b1;
					if (iss.op == MDU_OP_DIV || iss.op == MDU_OP_DIVU ||
						iss.op == MDU_OP_DDIV || iss.op == MDU_OP_DDIVU) begin
						st_d.fsm = MDU_ST_DIV;
						st_d.cnt = dw ? `MDU_DIV_D_STEPS : `MDU_DIV_W_STEPS;
						st_d.rem = 65'h0;
						st_d.quo = dw ? a_abs : {a_abs[31:0], 32'h0};
						st_d.dvsr = b_abs;
						st_d.neg_q = sa ^ sb;
						st_d.neg_r = sa;
					end else begin
						st_d.fsm = MDU_ST_MUL;
						st_d.cnt = `MDU_MUL_CYC;
						st_d.prod = p;
					end
				end
			end
			// product waits here while the pipeline runs on
			MDU_ST_MUL: begin
				st_d.cnt = st_q.cnt - 6'h01;
				if (st_q.cnt == 6'h01) begin
					st_d.fsm = MDU_ST_IDLE;
					st_d.busy = 1'b0;
					unique case (st_q.op)
						MDU_OP_MUL3: begin
							st_d.gpr_valid = 1'b1;
							st_d.gpr_data = sx32(st_q.prod[31:0]);
						end
						// pair acts as one 64-bit accumulator
						MDU_OP_MAD, MDU_OP_MADU: begin
							acc = {st_q.upper_result[31:0],
								st_q.bottom_result[31:0]} + st_q.prod[63:0];
							st_d.upper_result = sx32(acc[63:32]);
							st_d.bottom_result = sx32(acc[31:0]);
						end
						// full 128-bit product split in two
						MDU_OP_DMULT, MDU_OP_DMULTU: begin
							st_d.upper_result = st_q.prod[127:64];
							st_d.bottom_result = st_q.prod[63:0];
						end
						// high half upper, low half bottom
						default: begin
							st_d.upper_result = sx32(st_q.prod[63:32]);
							st_d.bottom_result = sx32(st_q.prod[31:0]);
						end
					endcase
				end
			end
			MDU_ST_DIV: begin
				// divisor of zero just runs out, all-ones quotient before the sign fix
				for (int i = 0; i < 2; i++) begin
					r = {r[63:0], q[63]};
					q = {q[62:0], 1'b0};
					if (r >= {1'b0, st_q.dvsr}) begin
						r = r - {1'b0, st_q.dvsr};
						q[0] = 1'b1;
					end
				end
				st_d.rem = r;
				st_d.quo = q;
				st_d.cnt = st_q.cnt - 6'h01;
				// last step also fixes signs and stores
				if (st_q.cnt == 6'h01) begin
					qf = st_q.neg_q ? (64'h0 - q) : q;
					rf = st_q.neg_r ? (64'h0 - r[63:0]) : r[63:0];
					st_d.fsm = MDU_ST_IDLE;
					st_d.busy = 1'b0;
					if (st_q.op == MDU_OP_DDIV || st_q.op == MDU_OP_DDIVU) begin
						st_d.bottom_result = qf;
						st_d.upper_result = rf;
					end else begin
						st_d.bottom_result = sx32(qf[31:0]);
						st_d.upper_result = sx32(rf[31:0]);
					end
				end
			end
			default: begin
				st_d.fsm = MDU_ST_IDLE;
				st_d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.fsm <= MDU_ST_IDLE;
			st_q.op <= MDU_OP_MULT;
			st_q.upper_result <= `MDU_RES_RST;
			st_q.bottom_result <= `MDU_RES_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// results leave through the read port, MUL3 products through the gpr write port
	assign busy = st_q.busy;
	assign rd_valid = st_q.rd_valid;
	assign rd_data = st_q.rd_data;
	assign gpr_wr_valid = st_q.gpr_valid;
	assign gpr_wr_data = st_q.gpr_data;

	// checks
	logic is_wdiv;
	logic is_ddiv;
	assign is_wdiv = take && (iss.op == MDU_OP_DIV || iss.op == MDU_OP_DIVU);
	assign is_ddiv = take && (iss.op == MDU_OP_DDIV || iss.op == MDU_OP_DDIVU);

	a_div_latency_bound: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (is_wdiv || is_ddiv) |-> ##[1:35] !busy)
		else $error("divide took longer than 35 cycles");

	a_ddiv_done_time: assert property (@(posedge sys_clk)
		disable iff (sys_rst) is_ddiv |=> busy [*8] ##25 !busy)
		else $error("doubleword divide timing wrong");

	a_issue_goes_busy: assert property (@(posedge sys_clk)
		disable iff (sys_rst) take |=> busy && !rd_valid)
		else $error("issue did not start background work");

	a_read_stalls: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (rd_req && busy) |=> !rd_valid)
		else $error("read answered while busy");

	a_read_answers: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(rd_req && !busy && !iss.valid && !rd_valid) |=> rd_valid)
		else $error("idle read not answered next cycle");

	a_read_select: assert property (@(posedge sys_clk)
		disable iff (sys_rst) rd_valid |-> rd_data == ($past(rd_sel)
			? $past(st_q.upper_result) : $past(st_q.bottom_result)))
		else $error("read returned wrong result register");

	a_divu_order: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (take && iss.op == MDU_OP_DIVU &&
		iss.source_a[31:0] == 32'h7 && iss.source_b[31:0] == 32'h2)
		|-> ##17 (st_q.bottom_result == 64'h3 &&
			st_q.upper_result == 64'h1))
		else $error("divide result placement wrong");

	a_zero_div_quiet: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (take && iss.op == MDU_OP_DIVU &&
		iss.source_b[31:0] == 32'h0)
		|-> ##17 (!busy && st_q.bottom_result == 64'hFFFF_FFFF_FFFF_FFFF))
		else $error("zero divisor not handled quietly");

	a_mul3_writes_gpr: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (take && iss.op == MDU_OP_MUL3)
		|-> ##5 (gpr_wr_valid && gpr_wr_data ==
			sx32($past(iss.source_a[31:0], 5) * $past(iss.source_b[31:0], 5))))
		else $error("three-operand product not written");

	a_mad_zero_keeps: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (take && iss.op == MDU_OP_MADU &&
		iss.source_b == 64'h0)
		|-> ##5 (st_q.bottom_result == $past(st_q.bottom_result, 5)))
		else $error("accumulate of zero product changed bottom");

	c_word_div: cover property (@(posedge sys_clk) is_wdiv ##17 !busy);
	c_dword_div: cover property (@(posedge sys_clk) is_ddiv);
	c_read_stall: cover property (@(posedge sys_clk)
		rd_req && busy ##[1:35] rd_valid);
	c_mul3: cover property (@(posedge sys_clk) gpr_wr_valid);

endmodule : mdu_unit

`default_nettype wire

// >>> include/mdu_pkg.sv
// types shared by the multiply/divide unit and its bench
// assumes 64-bit general registers; word forms use the low 32 bits
`default_nettype none

package mdu_pkg;

	typedef enum logic [3:0] {
		MDU_OP_MULT   = 4'h0,
		MDU_OP_MULTU  = 4'h1,
		MDU_OP_DIV    = 4'h2,
		MDU_OP_DIVU   = 4'h3,
		MDU_OP_DMULT  = 4'h4,
		MDU_OP_DMULTU = 4'h5,
		MDU_OP_DDIV   = 4'h6,
		MDU_OP_DDIVU  = 4'h7,
		MDU_OP_MAD    = 4'h8,
		MDU_OP_MADU   = 4'h9,
		MDU_OP_MUL3   = 4'hA
	} mdu_op_t;

	typedef enum logic [1:0] {
		MDU_ST_IDLE = 2'b00,
		MDU_ST_MUL  = 2'b01,
		MDU_ST_DIV  = 2'b10
	} mdu_fsm_t;

	// one issue from the pipeline: two register operands, no immediate
	typedef struct packed {
		logic        valid;
		mdu_op_t     op;
		logic [63:0] source_a;
		logic [63:0] source_b;
	} mdu_issue_t;

	typedef struct packed {
		mdu_fsm_t     fsm;
		mdu_op_t      op;
		logic [5:0]   cnt;
		logic [127:0] prod;
		logic [64:0]  rem;
		logic [63:0]  quo;
		logic [63:0]  dvsr;
		logic         neg_q;
		logic         neg_r;
		logic [63:0]  upper_result;
		logic [63:0]  bottom_result;
		logic         busy;
		logic         rd_valid;
		logic [63:0]  rd_data;
		logic         gpr_valid;
		logic [63:0]  gpr_data;
	} mdu_state_t;

endpackage : mdu_pkg

`default_nettype wire

// >>> include/mdu_regs.svh
// timing counts and reset values for the multiply/divide unit
// assumes the core clock of 8 ns; included by the unit only
`ifndef MDU_REGS_SVH
`define MDU_REGS_SVH

// core clock period in ns and divide latency ceiling in cycles
`define MDU_CLK_PERIOD_NS 8
`define MDU_DIV_MAX_CYC   35
// multiply latency, cycles from issue edge until results land
`define MDU_MUL_CYC       6'h04
// divide steps; two quotient bits retire per step
`define MDU_DIV_W_STEPS   6'h10
`define MDU_DIV_D_STEPS   6'h20
// result registers after reset
`define MDU_RES_RST       64'h0000_0000_0000_0000

`endif
